// ==== common/lvc_pkg.sv ====
package lvc_pkg;

   // ==========================================================
   // I/O port addresses (10-bit port space)
   // ==========================================================
   localparam logic [9:0] LVC_PORT_PEN_DATA_LO   = 10'h3B5;
   localparam logic [9:0] LVC_PORT_PEN_DATA_HI   = 10'h3D5;
   localparam logic [9:0] LVC_PORT_MONO_MODE     = 10'h3B8;
   localparam logic [9:0] LVC_PORT_MONO_PEN_SET  = 10'h3B9;
   localparam logic [9:0] LVC_PORT_MONO_STATUS   = 10'h3BA;
   localparam logic [9:0] LVC_PORT_MONO_PEN_CLR  = 10'h3BB;
   localparam logic [9:0] LVC_PORT_MONO_PERMIT   = 10'h3BF;
   localparam logic [9:0] LVC_PORT_COL_MODE      = 10'h3D8;
   localparam logic [9:0] LVC_PORT_COL_PALETTE   = 10'h3D9;
   localparam logic [9:0] LVC_PORT_COL_STATUS    = 10'h3DA;
   localparam logic [9:0] LVC_PORT_COL_PEN_CLR   = 10'h3DB;
   localparam logic [9:0] LVC_PORT_COL_PEN_SET   = 10'h3DC;

   // Index values presented by the display controller index register
   localparam logic [7:0] LVC_IDX_PEN_HIGH       = 8'h10;
   localparam logic [7:0] LVC_IDX_PEN_LOW        = 8'h11;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int LVC_CM_WIDE_COLS    = 0;
   localparam int LVC_CM_GRAPHICS     = 1;
   localparam int LVC_CM_COLOUR_OFF   = 2;
   localparam int LVC_CM_VIDEO_ON     = 3;
   localparam int LVC_CM_HIRES        = 4;
   localparam int LVC_CM_BLINK        = 5;
   localparam int LVC_CP_BRIGHT       = 4;
   localparam int LVC_CP_CHOICE       = 5;
   localparam int LVC_MM_GRAPHICS     = 1;
   localparam int LVC_MM_VIDEO_ON     = 3;
   localparam int LVC_MM_BLINK        = 5;
   localparam int LVC_MM_PAGE         = 7;
   localparam int LVC_PERMIT_GRAPHICS = 0;
   localparam int LVC_PERMIT_UPPER    = 1;

   // Writable bit masks; reserved bits are not stored and read as zero, except the write-only permit port, which reads FF
   localparam logic [7:0] LVC_COL_MODE_MASK  = 8'h3F;
   localparam logic [7:0] LVC_COL_PAL_MASK   = 8'h3F;
   localparam logic [7:0] LVC_MONO_MODE_MASK = 8'hAA;
   localparam logic [7:0] LVC_PERMIT_MASK    = 8'h03;

   // ==========================================================
   // Reset values and fixed read values
   // ==========================================================
   localparam logic [7:0]  LVC_RST_REG      = 8'h00;
   localparam logic [13:0] LVC_RST_PEN_ADDR = 14'h0000;
   localparam logic [7:0]  LVC_READ_UNDEF   = 8'hFF;

   // IRGB colour codes
   localparam logic [3:0] LVC_BLACK  = 4'h0;
   localparam logic [3:0] LVC_GREEN  = 4'h2;
   localparam logic [3:0] LVC_CYAN   = 4'h3;
   localparam logic [3:0] LVC_RED    = 4'h4;
   localparam logic [3:0] LVC_VIOLET = 4'h5;
   localparam logic [3:0] LVC_YELLOW = 4'h6;
   localparam logic [3:0] LVC_WHITE  = 4'h7;
   localparam logic [3:0] LVC_BRIGHT = 4'h8;

   // ==========================================================
   // Carriers
   // ==========================================================
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [9:0]  addr;
      logic [7:0]  wdata;
   } lvc_io_req_t;

   typedef struct packed {
      logic        any_blank;
      logic        hblank;
      logic        vsync;
      logic        mono_video;
      logic [13:0] refresh_addr;
   } lvc_timing_t;

   typedef struct packed {
      logic        wide_alpha_columns;
      logic        graphics_select;
      logic        two_colour_hires_on;
      logic        colour_disabled;
      logic        video_output_on;
      logic        char_blink_on;
      logic        display_page_select;
      logic        upper_page_reach;
      logic [3:0]  edge_backdrop_colour;
      logic        bright_backdrop;
   } lvc_display_t;

endpackage

// ==== design/lvc_regs.sv ====
`timescale 1ns/100ps
module lvc_regs
   import lvc_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire lvc_pkg::lvc_io_req_t  io_req,
   input  wire logic [7:0]            index_sel,
   input  wire logic                  port_base_select,
   input  wire logic                  legacy_mode_on,
   input  wire logic                  mono_emulation,
   input  wire logic                  ext_mono_on,
   input  wire lvc_pkg::lvc_timing_t  timing,
   input  wire logic [1:0]            pixel_code,
   output logic [7:0]                 io_rdata,
   output logic                       io_rd_claim,
   output lvc_pkg::lvc_display_t      display,
   output logic [3:0]                 pixel_colour,
   output logic                       pen_latch_flag
);
   import lvc_pkg::*;

   // ==========================================================
   // Helper functions
   // ==========================================================
   function automatic logic port_is(input logic [9:0] addr, input logic [9:0] port);
      port_is = (addr == port);
   endfunction

   // Pen data port moves with the port base select
   function automatic logic pen_data_port(input logic [9:0] addr, input logic base);
      pen_data_port = base ? (addr == LVC_PORT_PEN_DATA_HI)
                           : (addr == LVC_PORT_PEN_DATA_LO);
   endfunction

   function automatic logic [3:0] colour_lookup(input logic [1:0] code,
                                                input logic [7:0] mode,
                                                input logic [7:0] pal);
      logic [3:0] c;
      c = LVC_BLACK;
      if (mode[LVC_CM_HIRES]) begin
         c = (code[0]) ? pal[3:0] : LVC_BLACK;
      end else if (code == 2'b00) begin
         c = pal[3:0];
      end else begin
         if (mode[LVC_CM_COLOUR_OFF]) begin
            case (code)
               2'b01:   c = LVC_CYAN;
               2'b10:   c = LVC_RED;
               default: c = LVC_WHITE;
            endcase
         end else if (pal[LVC_CP_CHOICE]) begin
            case (code)
               2'b01:   c = LVC_CYAN;
               2'b10:   c = LVC_VIOLET;
               default: c = LVC_WHITE;
            endcase
         end else begin
            case (code)
               2'b01:   c = LVC_GREEN;
               2'b10:   c = LVC_RED;
               default: c = LVC_YELLOW;
            endcase
         end
         if (pal[LVC_CP_BRIGHT]) begin
            c = c | LVC_BRIGHT;
         end
      end
      colour_lookup = c;
   endfunction

   // ==========================================================
   // Access decode
   // ==========================================================
   logic wr_col_mode;
   logic wr_col_pal;
   logic wr_mono_mode;
   logic wr_permit;
   logic wr_pen_set;
   logic wr_pen_clr;

   assign wr_col_mode  = io_req.wr & port_is(io_req.addr, LVC_PORT_COL_MODE);
   assign wr_col_pal   = io_req.wr & port_is(io_req.addr, LVC_PORT_COL_PALETTE);
   assign wr_mono_mode = io_req.wr & port_is(io_req.addr, LVC_PORT_MONO_MODE);
   assign wr_permit    = io_req.wr & port_is(io_req.addr, LVC_PORT_MONO_PERMIT);
   // Data value is ignored on the pen ports
   assign wr_pen_set   = io_req.wr & (port_is(io_req.addr, LVC_PORT_COL_PEN_SET)
                                    | port_is(io_req.addr, LVC_PORT_MONO_PEN_SET));
   assign wr_pen_clr   = io_req.wr & (port_is(io_req.addr, LVC_PORT_COL_PEN_CLR)
                                    | port_is(io_req.addr, LVC_PORT_MONO_PEN_CLR));

   // ==========================================================
   // Colour adapter registers
   // ==========================================================
   logic [7:0] col_mode_q;
   logic [7:0] col_pal_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         col_mode_q <= LVC_RST_REG;
      end else if (wr_col_mode) begin
         col_mode_q <= io_req.wdata & LVC_COL_MODE_MASK;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         col_pal_q <= LVC_RST_REG;
      end else if (wr_col_pal) begin
         col_pal_q <= io_req.wdata & LVC_COL_PAL_MASK;
      end
   end

   // ==========================================================
   // Monochrome mode and permission registers
   // ==========================================================
   logic [7:0] mono_mode_q;
   logic [7:0] permit_q;
   logic [7:0] mono_mode_d;

   always_comb begin
      mono_mode_d = io_req.wdata & LVC_MONO_MODE_MASK;
      // Page bit cannot be set while the upper page is not permitted
      if (!permit_q[LVC_PERMIT_UPPER]) begin
         mono_mode_d[LVC_MM_PAGE] = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mono_mode_q <= LVC_RST_REG;
      end else if (wr_mono_mode) begin
         mono_mode_q <= mono_mode_d;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         permit_q <= LVC_RST_REG;
      end else if (wr_permit) begin
         permit_q <= io_req.wdata & LVC_PERMIT_MASK;
      end
   end

   // ==========================================================
   // Pen flag and address latch
   // ==========================================================
   logic        pen_flag_q;
   logic [13:0] pen_addr_q;

   // Set wins if both ever coincide, so an event is never lost
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pen_flag_q <= 1'b0;
      end else if (wr_pen_set) begin
         pen_flag_q <= 1'b1;
      end else if (wr_pen_clr) begin
         pen_flag_q <= 1'b0;
      end
   end

   // A repeated set while already set keeps the first capture
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pen_addr_q <= LVC_RST_PEN_ADDR;
      end else if (wr_pen_set && !pen_flag_q) begin
         pen_addr_q <= timing.refresh_addr;
      end
   end

   assign pen_latch_flag = pen_flag_q;

   // ==========================================================
   // Status words
   // ==========================================================
   logic [7:0] col_status;
   logic [7:0] ext_status;
   logic [7:0] mono_status;

   assign col_status  = {4'hF, timing.vsync, 1'b1, pen_flag_q,
                         timing.any_blank};
   assign ext_status  = {~timing.vsync, 3'h7, timing.mono_video, 1'b1, pen_flag_q,
                         timing.hblank};
   assign mono_status = {4'hF, timing.mono_video, 2'h3, timing.hblank};

   // ==========================================================
   // Read path
   // ==========================================================
   logic [7:0] rdata_d;
   logic       claim_d;
   logic [7:0] rdata_q;
   logic       claim_q;

   always_comb begin
      rdata_d = LVC_RST_REG;
      claim_d = 1'b0;
      if (io_req.rd) begin
         claim_d = 1'b1;
         if (port_is(io_req.addr, LVC_PORT_COL_MODE)) begin
            rdata_d = col_mode_q;
         end else if (port_is(io_req.addr, LVC_PORT_COL_PALETTE)) begin
            rdata_d = col_pal_q;
         end else if (port_is(io_req.addr, LVC_PORT_COL_STATUS)) begin
            rdata_d = col_status;
         end else if (port_is(io_req.addr, LVC_PORT_MONO_MODE)) begin
            rdata_d = mono_mode_q;
         end else if (port_is(io_req.addr, LVC_PORT_MONO_STATUS)) begin
            rdata_d = ext_mono_on ? ext_status : mono_status;
         end else if (port_is(io_req.addr, LVC_PORT_COL_PEN_CLR)
                   || port_is(io_req.addr, LVC_PORT_COL_PEN_SET)
                   || port_is(io_req.addr, LVC_PORT_MONO_PEN_SET)
                   || port_is(io_req.addr, LVC_PORT_MONO_PEN_CLR)
                   || port_is(io_req.addr, LVC_PORT_MONO_PERMIT)) begin
            rdata_d = LVC_READ_UNDEF;
         end else if (legacy_mode_on && pen_data_port(io_req.addr, port_base_select)
                      && (index_sel == LVC_IDX_PEN_HIGH)) begin
            rdata_d = {2'b00, pen_addr_q[13:8]};
         end else if (legacy_mode_on && pen_data_port(io_req.addr, port_base_select)
                      && (index_sel == LVC_IDX_PEN_LOW)) begin
            rdata_d = pen_addr_q[7:0];
         end else begin
            claim_d = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= LVC_RST_REG;
         claim_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         claim_q <= claim_d;
      end
   end

   assign io_rdata    = rdata_q;
   assign io_rd_claim = claim_q;

   // ==========================================================
   // Display control outputs
   // ==========================================================
   lvc_display_t disp_d;
   lvc_display_t disp_q;
   logic         mono_graphics;

   // Graphics in monochrome needs both the mode bit and the permission
   assign mono_graphics = ext_mono_on & mono_mode_q[LVC_MM_GRAPHICS]
                        & permit_q[LVC_PERMIT_GRAPHICS];

   always_comb begin
      disp_d = '0;
      if (mono_emulation) begin
         disp_d.wide_alpha_columns  = 1'b1;
         disp_d.graphics_select     = mono_graphics;
         disp_d.video_output_on     = mono_mode_q[LVC_MM_VIDEO_ON];
         disp_d.char_blink_on       = mono_mode_q[LVC_MM_BLINK];
         disp_d.display_page_select = mono_graphics & mono_mode_q[LVC_MM_PAGE]
                                    & permit_q[LVC_PERMIT_UPPER];
         disp_d.upper_page_reach    = permit_q[LVC_PERMIT_UPPER];
      end else begin
         disp_d.wide_alpha_columns  = col_mode_q[LVC_CM_WIDE_COLS];
         disp_d.graphics_select     = col_mode_q[LVC_CM_GRAPHICS];
         disp_d.two_colour_hires_on = col_mode_q[LVC_CM_HIRES];
         disp_d.colour_disabled     = col_mode_q[LVC_CM_COLOUR_OFF];
         disp_d.video_output_on     = col_mode_q[LVC_CM_VIDEO_ON];
         disp_d.char_blink_on       = col_mode_q[LVC_CM_BLINK];
         disp_d.edge_backdrop_colour = col_pal_q[3:0];
         disp_d.bright_backdrop     = col_pal_q[LVC_CP_BRIGHT];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         disp_q <= '0;
      end else begin
         disp_q <= disp_d;
      end
   end

   assign display = disp_q;

   // ==========================================================
   // Pixel colour mapping
   // ==========================================================
   logic [3:0] colour_q;

   // Video off or mono emulation shows black; blanking and alpha mode show the palette colour
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         colour_q <= LVC_BLACK;
      end else if (mono_emulation || !col_mode_q[LVC_CM_VIDEO_ON]) begin
         colour_q <= LVC_BLACK;
      end else if (timing.any_blank) begin
         colour_q <= col_pal_q[3:0];
      end else if (col_mode_q[LVC_CM_GRAPHICS]) begin
         colour_q <= colour_lookup(pixel_code, col_mode_q, col_pal_q);
      end else begin
         colour_q <= col_pal_q[3:0];
      end
   end

   assign pixel_colour = colour_q;

endmodule

// ==== verif/lvc_regs_asserts.sv ====
`timescale 1ns/100ps
module lvc_regs_asserts (
   input wire logic                 clk,
   input wire logic                 rst,
   input wire lvc_pkg::lvc_io_req_t io_req,
   input wire logic [7:0]           index_sel,
   input wire logic                 port_base_select,
   input wire logic                 legacy_mode_on,
   input wire logic                 mono_emulation,
   input wire logic                 ext_mono_on,
   input wire lvc_pkg::lvc_timing_t timing,
   input wire logic [7:0]           io_rdata,
   input wire logic                 io_rd_claim,
   input wire lvc_pkg::lvc_display_t display,
   input wire logic                 pen_latch_flag
);
   import lvc_pkg::*;
   // =====================================================
   // Helper decode
   // =====================================================
   wire logic [9:0] a = io_req.addr;
   wire logic [9:0] pen_port = port_base_select ? LVC_PORT_PEN_DATA_HI : LVC_PORT_PEN_DATA_LO;
   wire logic set_w = io_req.wr && (a == LVC_PORT_COL_PEN_SET || a == LVC_PORT_MONO_PEN_SET);
   wire logic clr_w = io_req.wr && (a == LVC_PORT_COL_PEN_CLR || a == LVC_PORT_MONO_PEN_CLR);
   wire logic wo_rd = io_req.rd && (a inside {LVC_PORT_COL_PEN_CLR, LVC_PORT_COL_PEN_SET,
      LVC_PORT_MONO_PEN_SET, LVC_PORT_MONO_PEN_CLR, LVC_PORT_MONO_PERMIT});
   wire logic pen_rd = io_req.rd && legacy_mode_on && a == pen_port;
   // Mirror of the latched address; only the 0 to 1 edge of the flag captures
   logic [13:0] cap_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) cap_q <= LVC_RST_PEN_ADDR;
      else if (set_w && !pen_latch_flag) cap_q <= timing.refresh_addr;
   end
   // =====================================================
   // Properties
   // =====================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   pen_set_a: assert property (set_w |=> pen_latch_flag)
      else $error("pen flag not set after set port write");
   pen_clr_a: assert property (clr_w |=> !pen_latch_flag)
      else $error("pen flag not cleared after clear port write");
   col_stat_a: assert property (io_req.rd && a == LVC_PORT_COL_STATUS |=> io_rd_claim &&
      io_rdata == {4'hF, $past(timing.vsync), 1'b1, $past(pen_latch_flag), $past(timing.any_blank)})
      else $error("colour status byte wrong");
   ext_stat_a: assert property (io_req.rd && a == LVC_PORT_MONO_STATUS && ext_mono_on |=>
      io_rdata == {~$past(timing.vsync), 3'b111, $past(timing.mono_video), 1'b1,
      $past(pen_latch_flag), $past(timing.hblank)}) else $error("extended status byte wrong");
   mono_stat_a: assert property (io_req.rd && a == LVC_PORT_MONO_STATUS && !ext_mono_on |=>
      io_rdata == {4'hF, $past(timing.mono_video), 2'b11, $past(timing.hblank)})
      else $error("mono status byte wrong");
   wo_read_a: assert property (wo_rd |=> io_rd_claim && io_rdata == LVC_READ_UNDEF &&
      pen_latch_flag == $past(pen_latch_flag)) else $error("write-only port read misbehaved");
   pen_high_a: assert property (pen_rd && index_sel == LVC_IDX_PEN_HIGH |=>
      io_rd_claim && io_rdata == {2'b00, cap_q[13:8]}) else $error("pen high byte wrong");
   pen_low_a: assert property (pen_rd && index_sel == LVC_IDX_PEN_LOW |=>
      io_rd_claim && io_rdata == cap_q[7:0]) else $error("pen low byte wrong");
   pen_refuse_a: assert property (io_req.rd && (a == LVC_PORT_PEN_DATA_HI ||
      a == LVC_PORT_PEN_DATA_LO) && !(legacy_mode_on && a == pen_port) |=> !io_rd_claim)
      else $error("pen port answered when it should not");
   col_mode_a: assert property (io_req.wr && a == LVC_PORT_COL_MODE && !mono_emulation
      ##1 !(io_req.wr && a == LVC_PORT_COL_MODE) |=> {display.char_blink_on,
      display.two_colour_hires_on, display.video_output_on, display.colour_disabled,
      display.graphics_select, display.wide_alpha_columns} == $past(io_req.wdata[5:0], 2))
      else $error("colour mode fields not on display outputs");
endmodule

bind lvc_regs lvc_regs_asserts i_lvc_regs_asserts (.clk(clk), .rst(rst), .io_req(io_req),
   .index_sel(index_sel), .port_base_select(port_base_select), .legacy_mode_on(legacy_mode_on),
   .mono_emulation(mono_emulation), .ext_mono_on(ext_mono_on), .timing(timing),
   .io_rdata(io_rdata), .io_rd_claim(io_rd_claim), .display(display),
   .pen_latch_flag(pen_latch_flag));

// ==== verif/testbench.sv ====
`timescale 1ns/100ps
module testbench;
   import lvc_pkg::*;
   logic         clk, rst, port_base_select, legacy_mode_on, mono_emulation, ext_mono_on;
   lvc_io_req_t  io_req;
   lvc_timing_t  timing;
   lvc_display_t display;
   logic [7:0]   index_sel, io_rdata, rd_v, m, p, q;
   logic [1:0]   pixel_code;
   logic [3:0]   pixel_colour;
   logic         io_rd_claim, pen_latch_flag, fl;
   logic [15:0]  rnd;
   logic [13:0]  ra;
   logic [9:0]   wo [5];
   int           err_count, n_checks;

   lvc_regs i_lvc_regs (.clk(clk), .rst(rst), .io_req(io_req), .index_sel(index_sel),
      .port_base_select(port_base_select), .legacy_mode_on(legacy_mode_on),
      .mono_emulation(mono_emulation), .ext_mono_on(ext_mono_on), .timing(timing),
      .pixel_code(pixel_code), .io_rdata(io_rdata), .io_rd_claim(io_rd_claim),
      .display(display), .pixel_colour(pixel_colour), .pen_latch_flag(pen_latch_flag));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // =====================================================
   // Helpers
   // =====================================================
   function automatic logic [15:0] lfsr16(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic rnd8(output logic [7:0] v);
      rnd = lfsr16(rnd);
      v = rnd[7:0];
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic io_wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk) io_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge clk) io_req <= '0;
   endtask
   // Data is checked only where the port answers; a refused read returns 00 and is not checked
   task automatic rdc(input logic [9:0] a, input logic [7:0] d, input logic c);
      @(posedge clk) io_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge clk) io_req <= '0;
      @(negedge clk) rd_v = io_rdata;
      chk({7'h0, io_rd_claim}, {7'h0, c});
      if (c) chk(rd_v, d);
   endtask
   function automatic logic [3:0] exp_pix(input logic [7:0] md, input logic [7:0] pl,
                                          input logic [1:0] c);
      logic [3:0] k;
      if (!md[3]) return LVC_BLACK;
      if (md[4]) return c[0] ? pl[3:0] : LVC_BLACK;
      if (c == 2'd0) return pl[3:0];
      if (md[2]) k = (c == 2'd1) ? LVC_CYAN : (c == 2'd2) ? LVC_RED : LVC_WHITE;
      else if (pl[5]) k = (c == 2'd1) ? LVC_CYAN : (c == 2'd2) ? LVC_VIOLET : LVC_WHITE;
      else k = (c == 2'd1) ? LVC_GREEN : (c == 2'd2) ? LVC_RED : LVC_YELLOW;
      return k | (pl[4] ? LVC_BRIGHT : 4'h0);
   endfunction
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #400000;
      err_count++;
      wrap_up();
   end
   // =====================================================
   // Main sequence
   // =====================================================
   initial begin
      io_req = '0;
      timing = '0;
      index_sel = 8'h00;
      port_base_select = 1'b1;
      legacy_mode_on = 1'b1;
      mono_emulation = 1'b0;
      ext_mono_on = 1'b1;
      pixel_code = 2'b00;
      rnd = 16'd19942;
      wo = '{LVC_PORT_COL_PEN_CLR, LVC_PORT_COL_PEN_SET, LVC_PORT_MONO_PEN_SET,
             LVC_PORT_MONO_PEN_CLR, LVC_PORT_MONO_PERMIT};
      rst = 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rdc(LVC_PORT_COL_MODE, 8'h00, 1'b1);
      rdc(LVC_PORT_COL_PALETTE, 8'h00, 1'b1);
      rdc(LVC_PORT_MONO_MODE, 8'h00, 1'b1);
      // Colour set: random mode and palette, first pass writes reserved bits too
      for (int i = 0; i < 12; i++) begin
         rnd8(m);
         rnd8(p);
         m[1] = i[0];
         if (i == 0) m = 8'hFF;
         if (i == 0) p = 8'hFF;
         io_wr(LVC_PORT_COL_MODE, m);
         io_wr(LVC_PORT_COL_PALETTE, p);
         rdc(LVC_PORT_COL_MODE, m & LVC_COL_MODE_MASK, 1'b1);
         rdc(LVC_PORT_COL_PALETTE, p & LVC_COL_PAL_MASK, 1'b1);
         chk({2'b00, display.char_blink_on, display.two_colour_hires_on,
              display.video_output_on, display.colour_disabled, display.graphics_select,
              display.wide_alpha_columns}, m & 8'h3F);
         chk({3'h0, display.bright_backdrop, display.edge_backdrop_colour},
             {3'h0, p[4:0]});
         for (int c = 0; c < 4; c++) begin
            if (!m[1] || (m[4] && c > 1)) continue;
            @(posedge clk) pixel_code <= c[1:0];
            repeat (2) @(negedge clk);
            chk({4'h0, pixel_colour}, {4'h0, exp_pix(m, p, c[1:0])});
         end
      end
      // Border interval shows the palette colour whenever video is on
      @(posedge clk) timing.any_blank <= 1'b1;
      repeat (2) @(negedge clk);
      chk({4'h0, pixel_colour}, m[3] ? {4'h0, p[3:0]} : 8'h00);
      @(posedge clk) timing.any_blank <= 1'b0;
      // Pen flag and address latch on both port bases
      for (int b = 0; b < 2; b++) begin
         rnd8(q);
         ra = rnd[13:0];
         @(posedge clk) port_base_select <= b[0];
         io_wr(b ? LVC_PORT_COL_PEN_CLR : LVC_PORT_MONO_PEN_CLR, q);
         @(negedge clk) chk({7'h0, pen_latch_flag}, 8'h00);
         @(posedge clk) timing.refresh_addr <= ra;
         timing.vsync <= 1'b1;
         rdc(LVC_PORT_COL_STATUS, {4'hF, 1'b1, 1'b1, 1'b0, 1'b0}, 1'b1);
         io_wr(b ? LVC_PORT_COL_PEN_SET : LVC_PORT_MONO_PEN_SET, ~q);
         @(negedge clk) chk({7'h0, pen_latch_flag}, 8'h01);
         @(posedge clk) timing.refresh_addr <= ~ra;
         io_wr(b ? LVC_PORT_COL_PEN_SET : LVC_PORT_MONO_PEN_SET, q);
         index_sel <= LVC_IDX_PEN_HIGH;
         rdc(b ? LVC_PORT_PEN_DATA_HI : LVC_PORT_PEN_DATA_LO, {2'b00, ra[13:8]}, 1'b1);
         index_sel <= LVC_IDX_PEN_LOW;
         rdc(b ? LVC_PORT_PEN_DATA_HI : LVC_PORT_PEN_DATA_LO, ra[7:0], 1'b1);
         rdc(b ? LVC_PORT_PEN_DATA_LO : LVC_PORT_PEN_DATA_HI, 8'h00, 1'b0);
      end
      legacy_mode_on <= 1'b0;
      rdc(LVC_PORT_PEN_DATA_HI, 8'h00, 1'b0);
      legacy_mode_on <= 1'b1;
      // Status bytes under random timing levels and flag state
      for (int i = 0; i < 10; i++) begin
         rnd8(q);
         fl = q[5];
         io_wr(fl ? LVC_PORT_COL_PEN_SET : LVC_PORT_MONO_PEN_CLR, q);
         timing <= '{any_blank: q[0], hblank: q[1], vsync: q[2], mono_video: q[3],
                     refresh_addr: 14'h0000};
         ext_mono_on <= q[4];
         rdc(LVC_PORT_COL_STATUS, {4'hF, q[2], 1'b1, fl, q[0]}, 1'b1);
         rdc(LVC_PORT_MONO_STATUS, q[4] ? {~q[2], 3'b111, q[3], 1'b1, fl, q[1]} :
             {4'hF, q[3], 2'b11, q[1]}, 1'b1);
      end
      for (int i = 0; i < 5; i++) begin
         rdc(wo[i], LVC_READ_UNDEF, 1'b1);
         chk({7'h0, pen_latch_flag}, {7'h0, fl});
      end
      rdc(10'h3C0, 8'h00, 1'b0);
      // Monochrome set under each permission setting
      @(posedge clk) mono_emulation <= 1'b1;
      ext_mono_on <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         io_wr(LVC_PORT_MONO_PERMIT, k[7:0]);
         io_wr(LVC_PORT_MONO_MODE, 8'hFF);
         rdc(LVC_PORT_MONO_MODE, k[1] ? 8'hAA : 8'h2A, 1'b1);
         chk({2'b00, display.wide_alpha_columns, display.graphics_select,
              display.display_page_select, display.upper_page_reach, display.video_output_on,
              display.char_blink_on},
             {2'b00, 1'b1, k[0], k[0] & k[1], k[1], 2'b11});
      end
      wrap_up();
   end
endmodule
